/* pkg/host_port_map.vh */
// Constants for the ISA-mode host port address decoder
`ifndef HOST_PORT_MAP_VH
`define HOST_PORT_MAP_VH
// Register offsets (byte-wide register index, host address = 2 x offset)
`define OFS_DATA_PORT    5'h10
`define OFS_RESERVED     5'h11
`define OFS_HALF_LANE    5'h1E
`define OFS_RESET        5'h1F
// Host address limits
`define ADDR_REG_TOP     12'h03F
`define ADDR_WIN_BASE    12'h800
// Page of the power management register and its offset
`define PAGE_PWR         2'h3
`define OFS_PWR_MGMT     5'h0B
`define PWR_MGMT_RESET   8'h00
`define REG_STANDBY_BIT  4
// Page select field inside register offset 0 of page 0
`define PAGE_LSB         6
// Reset pulse length after a read of the reset offset, in ns
`define RESET_PULSE_NS   40
`define CLK_PERIOD_NS    4
// Pulse length in clock cycles: 40 ns at a 4 ns clock, sized for the counter
`define RESET_PULSE_CYC  4'hA
`endif

/* design/word_fifo.v */
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             rstN,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);
  // ==========================================================
  // Storage and pointers
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1]; // Word storage
  reg [AW-1:0]    wrPtr_ff;           // Next write slot
  reg [AW-1:0]    rdPtr_ff;           // Next read slot
  reg [AW:0]      count_ff;           // Words held
  wire push = inValid & inReady;
  wire pop  = outValid & outReady;
  assign inReady  = (count_ff != DEPTH[AW:0]);
  assign outValid = (count_ff != {(AW+1){1'b0}});
  assign outData  = mem_ff[rdPtr_ff];
  // Pointer and count update
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) wrPtr_ff <= (wrPtr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_ff + 1'b1;
      if (pop)  rdPtr_ff <= (rdPtr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_ff + 1'b1;
      count_ff <= count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
  // Data write, no reset needed on storage
  always @(posedge clk) begin
    if (push) mem_ff[wrPtr_ff] <= inData;
  end
endmodule // word_fifo

/* design/host_port_decoder.v */
// ISA-mode 16-bit host port address decoder with data port and register file
`timescale 1ns/1ps
`include "host_port_map.vh"
module host_port_decoder #(
  parameter ADDR_W = 12,
  parameter FIFO_DEPTH = 8
) (
  sys_clk,
  rst_n,
  memSelectStrap,
  memClockStrap,
  hostAddr,
  hostRdStb,
  hostWrStb,
  hostDataIn,
  hostDataOut,
  hostDataOe,
  txWord,
  txValid,
  txReady,
  rxWord,
  rxValid,
  rxReady,
  isaMode,
  regulatorStandby,
  deviceResetPulse
);
  input  wire              sys_clk;          // 250 MHz system clock
  input  wire              rst_n;            // Async active-low reset
  input  wire              memSelectStrap;   // Serial memory select strap pin
  input  wire              memClockStrap;    // Serial memory clock strap pin
  input  wire [ADDR_W-1:0] hostAddr;         // Host address A[11:0]
  input  wire              hostRdStb;        // Host read strobe, active high
  input  wire              hostWrStb;        // Host write strobe, active high
  input  wire [15:0]       hostDataIn;       // Host data lanes, input side
  output reg  [15:0]       hostDataOut;      // Host data lanes, output side
  output reg               hostDataOe;       // High while driving data lanes
  output reg  [15:0]       txWord;           // Word toward packet buffer
  output reg               txValid;          // Word valid toward buffer
  input  wire              txReady;          // Buffer accepts a word
  input  wire [15:0]       rxWord;           // Received word from buffer
  input  wire              rxValid;          // Received word available
  output reg               rxReady;          // Pop pulse toward buffer
  output reg               isaMode;          // Strap-decoded bus mode
  output reg               regulatorStandby; // Regulator standby control
  output reg               deviceResetPulse; // Device reset request

  // ==========================================================
  // Reset release and input synchronisers
  reg [1:0] rstSync_ff;                // Reset release chain
  wire      rstN = rstSync_ff[1];      // Internal reset copy
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rstSync_ff <= 2'h0;
    else        rstSync_ff <= {rstSync_ff[0], 1'b1};
  end

  // Two-flop synchronisers for pins; stage 1 read only by stage 2
  reg [ADDR_W+19:0] pinS1_ff;          // First stage
  reg [ADDR_W+19:0] pinS2_ff;          // Second stage
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      pinS1_ff <= {(ADDR_W+20){1'b0}};
      pinS2_ff <= {(ADDR_W+20){1'b0}};
    end else begin
      pinS1_ff <= {memSelectStrap, memClockStrap, hostRdStb, hostWrStb, hostDataIn, hostAddr};
      pinS2_ff <= pinS1_ff;
    end
  end
  wire [ADDR_W-1:0] addrS = pinS2_ff[ADDR_W-1:0];
  wire [15:0]       dataS = pinS2_ff[ADDR_W+15:ADDR_W];
  wire              wrS   = pinS2_ff[ADDR_W+16];
  wire              rdS   = pinS2_ff[ADDR_W+17];
  wire              clkStrapS = pinS2_ff[ADDR_W+18];
  wire              selStrapS = pinS2_ff[ADDR_W+19];

  // ==========================================================
  // Strap capture once after reset release
  // The straps pass the same two flip-flops as the bus pins, so the
  // second stage holds a real pin value only from the second edge on.
  // Capturing earlier would latch the flops' reset zeros instead.
  reg [1:0] strapAge_ff;  // Edges since internal reset release
  reg       strapDone_ff; // Straps latched
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      strapAge_ff  <= 2'h0;
      strapDone_ff <= 1'b0;
      isaMode      <= 1'b0;
    end else begin
      // Shift in ones until the synchroniser is filled
      strapAge_ff <= {strapAge_ff[0], 1'b1};
      if (strapAge_ff[1] & ~strapDone_ff) begin
        // Mode is fixed until the next reset
        strapDone_ff <= 1'b1;
        isaMode      <= ~selStrapS & ~clkStrapS;
      end
    end
  end

  // ==========================================================
  // Strobe edge detection on synchronised strobes
  reg rdD_ff; // Previous read strobe
  reg wrD_ff; // Previous write strobe
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      rdD_ff <= 1'b0;
      wrD_ff <= 1'b0;
    end else begin
      rdD_ff <= rdS;
      wrD_ff <= wrS;
    end
  end
  wire rdStart = rdS & ~rdD_ff & isaMode;
  wire wrStart = wrS & ~wrD_ff & isaMode;

  // ==========================================================
  // Address decode
  wire [4:0] regOfs   = addrS[5:1];
  wire       inWindow = addrS[ADDR_W-1];
  wire       inRegs   = ~inWindow & (addrS <= `ADDR_REG_TOP);
  wire       isData   = inWindow | (inRegs & regOfs == `OFS_DATA_PORT);
  wire       isResv   = inRegs & regOfs == `OFS_RESERVED;
  wire       isReg    = inRegs & ~isData & ~isResv;

  // Register file: 4 pages of 32 bytes
  reg  [7:0] regs_ff [0:127]; // Byte registers
  wire [1:0] page = regs_ff[0][`PAGE_LSB+1:`PAGE_LSB];

  // Flat index of a byte register in the current page
  function [6:0] regIdx;
    input [1:0] pg;
    input [4:0] ofs;
    begin
      regIdx = {pg, ofs};
    end
  endfunction

  // ==========================================================
  // Receive FIFO: buffer words wait here for host reads
  wire [15:0] rxHead;   // Oldest received word
  wire        rxHave;   // FIFO not empty
  reg         popFifo;  // Host consumed a word
  wire        fifoInReady;
  word_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH), .AW(3)) rxFifo (
    .clk      (sys_clk),
    .rstN     (rstN),
    .inData   (rxWord),
    .inValid  (rxValid & rxReady),
    .inReady  (fifoInReady),
    .outData  (rxHead),
    .outValid (rxHave),
    .outReady (popFifo)
  );

  // ==========================================================
  // Receive handshake toward the buffer
  // The ready output is registered, so it always reflects the FIFO fill
  // of one cycle ago. Raising it only every other cycle means a word is
  // never offered into a FIFO that the previous push has just filled;
  // this halves the fill rate, which host reads never outpace anyway.
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      rxReady <= 1'b0;
    end else begin
      // Ready again only after a cycle without a push
      rxReady <= fifoInReady & ~rxReady;
    end
  end

  // ==========================================================
  // Reset pulse counter for a read of offset 1Fh
  // The pulse is stretched to a fixed length so that logic far from
  // the port sees it even when it samples slowly.
  reg [3:0] rstCnt_ff;  // Remaining pulse cycles
  reg       rstLoad;    // Reset read taken this cycle
  integer   i;          // Register file reset index

  // Load marker for the pulse counter
  always @* begin
    rstLoad = rdStart & isReg & (regOfs == `OFS_RESET);
  end

  // Countdown and pulse output; a new reset read restarts the count
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      rstCnt_ff        <= 4'h0;
      deviceResetPulse <= 1'b0;
    end else begin
      // Output high while any count remains
      deviceResetPulse <= (rstCnt_ff != 4'h0);
      if (rstLoad) begin
        // Restart at the full length
        rstCnt_ff <= `RESET_PULSE_CYC;
      end else if (rstCnt_ff != 4'h0) begin
        // Count down toward idle
        rstCnt_ff <= rstCnt_ff - 4'h1;
      end
    end
  end

  // ==========================================================
  // Regulator standby output
  // Registered so the control never glitches while the decode settles
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      regulatorStandby <= 1'b0;
    end else begin
      // A grounded supply pin needs 0 here; a powered one in standby 1
      regulatorStandby <= regs_ff[{`PAGE_PWR, `OFS_PWR_MGMT}][`REG_STANDBY_BIT];
    end
  end

  // ==========================================================
  // Host read and write handling
  always @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      hostDataOut <= 16'h0000;
      hostDataOe  <= 1'b0;
      txWord      <= 16'h0000;
      txValid     <= 1'b0;
      popFifo     <= 1'b0;
      for (i = 0; i < 128; i = i + 1) begin
        regs_ff[i] <= 8'h00;
      end
    end else begin
      // Pop request lasts one cycle only
      popFifo <= 1'b0;
      // A word offered to the buffer stays until it is taken or a new data write replaces it
      if (txValid & txReady) begin
        txValid <= 1'b0;
      end
      // Lanes are released once the synchronised strobe is low
      if (!rdS) begin
        hostDataOe <= 1'b0;
      end
      if (rdStart) begin
        hostDataOe <= 1'b1;
        if (isData) begin
          // Each read takes the next buffer word; empty reads give zero
          hostDataOut <= rxHave ? rxHead : 16'h0000;
          popFifo     <= rxHave;
        end else if (isReg) begin
          if (regOfs == `OFS_RESET) begin
            // The reset read carries no register content
            hostDataOut <= 16'h0000;
          end else if (regOfs == `OFS_HALF_LANE) begin
            // Only the low lane is meaningful here
            hostDataOut <= {8'h00, regs_ff[regIdx(page, regOfs)]};
          end else if (!regOfs[0]) begin
            // Even offset pairs with the odd register above it
            hostDataOut <= {regs_ff[regIdx(page, regOfs | 5'h01)],
                            regs_ff[regIdx(page, regOfs)]};
          end else begin
            // Odd offset is copied to both lanes
            hostDataOut <= {regs_ff[regIdx(page, regOfs)],
                            regs_ff[regIdx(page, regOfs)]};
          end
        end else begin
          // Reserved and unused space reads as zero and touches nothing
          hostDataOut <= 16'h0000;
        end
      end
      if (wrStart) begin
        if (isData) begin
          // Both lanes go to the buffer; a pending word is replaced,
          // so software must not write faster than the buffer drains
          txWord  <= dataS;
          txValid <= 1'b1;
        end else if (isReg) begin
          // Low lane only; the high lane is dropped
          regs_ff[regIdx(page, regOfs)] <= dataS[7:0];
        end
      end
    end
  end
endmodule // host_port_decoder

/* testbench/host_port_props.sv */
// Concurrent checks on the host port decoder pins
`timescale 1ns/1ps
module host_port_props #(
  parameter ADDR_W = 12
) (
  input wire              sys_clk,
  input wire              rst_n,
  input wire              memSelectStrap,
  input wire              memClockStrap,
  input wire [ADDR_W-1:0] hostAddr,
  input wire              hostRdStb,
  input wire              hostWrStb,
  input wire [15:0]       hostDataOut,
  input wire              hostDataOe,
  input wire [15:0]       txWord,
  input wire              txValid,
  input wire              txReady,
  input wire              isaMode,
  input wire              regulatorStandby,
  input wire              deviceResetPulse
);
  // ==========================================================
  // Clocking and helper decode
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Unused gap below the window, or the reserved slot beside the data port
  wire unusedRd = !hostAddr[11] && (hostAddr[10:6] != 5'h00 || hostAddr[5:1] == 5'h11);
  // ==========================================================
  // Assertions
  mode_from_straps_a: assert property ($rose(isaMode) |-> $past(!memSelectStrap && !memClockStrap, 3)) else $error("mode latched with strap pulled up");
  read_answer_a: assert property ($rose(hostRdStb) && isaMode && hostAddr[11:1] != 11'h01F |-> ##[2:5] hostDataOe) else $error("read not answered in time");
  oe_needs_read_a: assert property (hostDataOe |-> hostRdStb || $past(hostRdStb) || $past(hostRdStb, 2) || $past(hostRdStb, 3)) else $error("lanes driven without a read");
  odd_lane_copy_a: assert property ($rose(hostDataOe) && !hostAddr[11] && hostAddr[1] && hostAddr[5:1] != 5'h1F |-> hostDataOut[15:8] == hostDataOut[7:0]) else $error("odd offset lanes differ");
  half_lane_a: assert property ($rose(hostDataOe) && hostAddr[11:1] == 11'h01E |-> hostDataOut[15:8] == 8'h00) else $error("high lane set at offset 1E");
  unused_zero_a: assert property ($rose(hostDataOe) && unusedRd |-> hostDataOut == 16'h0000) else $error("unused space returned data");
  reset_read_a: assert property ($rose(hostRdStb) && isaMode && hostAddr[11:1] == 11'h01F |-> ##[2:6] deviceResetPulse) else $error("reset read gave no pulse");
  standby_cause_a: assert property ($changed(regulatorStandby) |-> $past(hostWrStb) || deviceResetPulse || $past(deviceResetPulse)) else $error("standby moved without a write");
  tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txWord)) else $error("stalled word dropped or changed");
  tx_cause_a: assert property ($rose(txValid) |-> $past(hostWrStb)) else $error("word sent without a write");
  // ==========================================================
  // Coverage of the main scenarios
  cov_stall_c: cover property (txValid && !txReady);
  cov_window_c: cover property ($rose(hostDataOe) && hostAddr[11]);
  cov_reset_c: cover property ($rose(deviceResetPulse));
endmodule // host_port_props
bind host_port_decoder host_port_props #(.ADDR_W(ADDR_W)) props (.sys_clk(sys_clk), .rst_n(rst_n),
  .memSelectStrap(memSelectStrap), .memClockStrap(memClockStrap), .hostAddr(hostAddr),
  .hostRdStb(hostRdStb), .hostWrStb(hostWrStb), .hostDataOut(hostDataOut),
  .hostDataOe(hostDataOe), .txWord(txWord), .txValid(txValid), .txReady(txReady),
  .isaMode(isaMode), .regulatorStandby(regulatorStandby), .deviceResetPulse(deviceResetPulse));

/* testbench/host_bus_master.sv */
// Behavioural host processor driving the 16-bit external bus
`timescale 1ns/1ps
module host_bus_master (
  input  wire        sys_clk,
  output reg  [11:0] hostAddr,
  output reg         hostRdStb,
  output reg         hostWrStb,
  output reg  [15:0] hostDataIn,
  input  wire [15:0] hostDataOut,
  input  wire        hostDataOe
);
  // ==========================================================
  // Idle bus; released data lines show the inverse of the last value
  initial begin
    hostAddr   = 12'h000;
    hostRdStb  = 1'b0;
    hostWrStb  = 1'b0;
    hostDataIn = 16'h0000;
  end
  // Single read: hold until the lanes are driven, bounded wait
  task busRead(input [11:0] a, output [15:0] d);
    integer n;
    begin
      @(negedge sys_clk);
      hostAddr  = a;
      hostRdStb = 1'b1;
      n = 0;
      while (hostDataOe !== 1'b1 && n < 20) begin
        @(negedge sys_clk);
        n = n + 1;
      end
      d = (n < 20) ? hostDataOut : 16'hXXXX;
      hostRdStb = 1'b0;
      repeat (4) @(negedge sys_clk); // Low gap longer than three cycles
    end
  endtask
  // Single write: no acknowledge, so the strobe is held past the take point
  task busWrite(input [11:0] a, input [15:0] d);
    begin
      @(negedge sys_clk);
      hostAddr   = a;
      hostDataIn = d;
      hostWrStb  = 1'b1;
      repeat (6) @(negedge sys_clk);
      hostWrStb  = 1'b0;
      hostDataIn = ~d;
      repeat (4) @(negedge sys_clk);
    end
  endtask
endmodule // host_bus_master

/* testbench/isa_host_port_address_map_test.sv */
// Self-checking bench for the host port decoder
`timescale 1ns/1ps
`include "host_port_map.vh"
module isa_host_port_address_map_test;
  reg         sys_clk, rst_n, txReady;
  reg         selStrap, clkStrap;
  reg  [15:0] rxWord;
  reg  [15:0] rd;
  reg         popSeen_ff, pulseSeen_ff;
  integer     failures, checks, txCnt_ff, pulseLen_ff, i;
  wire [11:0] hostAddr;
  wire [15:0] hostDataIn, hostDataOut, txWord;
  wire        hostRdStb, hostWrStb, hostDataOe, txValid, rxReady, isaMode, standby, devRst;
  // ==========================================================
  // Design, host model and buffer-side stream
  host_port_decoder #(.ADDR_W(12), .FIFO_DEPTH(8)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .memSelectStrap(selStrap), .memClockStrap(clkStrap), .hostAddr(hostAddr),
    .hostRdStb(hostRdStb),
    .hostWrStb(hostWrStb), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
    .hostDataOe(hostDataOe), .txWord(txWord), .txValid(txValid), .txReady(txReady),
    .rxWord(rxWord), .rxValid(1'b1), .rxReady(rxReady), .isaMode(isaMode),
    .regulatorStandby(standby), .deviceResetPulse(devRst));
  host_bus_master host (.sys_clk(sys_clk), .hostAddr(hostAddr), .hostRdStb(hostRdStb),
    .hostWrStb(hostWrStb), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
    .hostDataOe(hostDataOe));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Monitors: pops, accepted words and reset pulse width
  always @(posedge sys_clk) begin
    popSeen_ff <= rxReady === 1'b1;
    if (txValid === 1'b1 && txReady) txCnt_ff <= txCnt_ff + 1;
    if (devRst === 1'b1) pulseLen_ff <= pulseLen_ff + 1;
    if (devRst === 1'b1) pulseSeen_ff <= 1'b1;
  end
  // Next received word appears off the sampling edge
  always @(negedge sys_clk) if (popSeen_ff) rxWord <= rxWord + 16'h0001;
  // ==========================================================
  // Comparison and closing
  task check(input [15:0] seen, input [15:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #60000;
    failures = failures + 1;
    end_of_test;
  end
  // ==========================================================
  // Main sequence
  initial begin
    failures = 0; checks = 0; txCnt_ff = 0; pulseLen_ff = 0;
    rst_n = 1'b0; txReady = 1'b0; rxWord = 16'h1000; popSeen_ff = 1'b0; pulseSeen_ff = 1'b0;
    selStrap = 1'b0; clkStrap = 1'b0;
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (10) @(negedge sys_clk);
    check({15'h0, isaMode}, 16'h0001);
    // Page 3 selected, standby bit set; high lane must not leak in
    host.busWrite(12'h000, 16'hFFC0);
    host.busWrite(12'h016, 16'hAB10);
    check({15'h0, standby}, 16'h0001);
    host.busRead(12'h016, rd); check(rd, 16'h1010);
    host.busRead(12'h014, rd); check({8'h00, rd[15:8]}, 16'h0010);
    host.busWrite(12'h016, 16'hFF00);
    check({15'h0, standby}, 16'h0000);
    host.busRead(12'h017, rd); check(rd, 16'h0000);
    host.busRead(12'h03C, rd); check({8'h00, rd[15:8]}, 16'h0000);
    // Data port, then a burst through the window, each read a new word
    host.busRead(12'h020, rd); check(rd, 16'h1000);
    for (i = 0; i < 4; i = i + 1) begin
      host.busRead(12'h800 + 2 * i, rd); check(rd, 16'h1001 + i);
    end
    host.busRead(12'hFFE, rd); check(rd, 16'h1005);
    // Reserved and unused places leave the stream alone
    host.busRead(12'h022, rd); check(rd, 16'h0000);
    host.busRead(12'h400, rd); check(rd, 16'h0000);
    host.busRead(12'h020, rd); check(rd, 16'h1006);
    // Writes to the data port with the buffer stalling
    host.busWrite(12'h020, 16'h5A5A);
    check({15'h0, txValid}, 16'h0001);
    check(txWord, 16'h5A5A);
    txReady = 1'b1;
    repeat (3) @(negedge sys_clk);
    txReady = 1'b0;
    host.busWrite(12'h9AC, 16'hC3C3);
    check(txWord, 16'hC3C3);
    txReady = 1'b1;
    host.busWrite(12'h044, 16'h1111);
    host.busWrite(12'h022, 16'h2222);
    check(txCnt_ff[15:0], 16'h0002);
    check({15'h0, standby}, 16'h0000);
    // Writing the reset offset only stores; reading it resets
    host.busWrite(12'h03E, 16'h0001);
    check({15'h0, pulseSeen_ff}, 16'h0000);
    host.busRead(12'h03E, rd);
    repeat (20) @(negedge sys_clk);
    check(pulseLen_ff[15:0], `RESET_PULSE_CYC);
    // Second power-up with the clock strap pulled up: bus mode stays off
    clkStrap = 1'b1;
    rst_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (10) @(negedge sys_clk);
    check({15'h0, isaMode}, 16'h0000);
    check({15'h0, standby}, 16'h0000);
    end_of_test;
  end
endmodule // isa_host_port_address_map_test
